/* osmc_mode_ctrl.sv */
// occupancy sensing mode control: modes, presence, check mode, leds
`timescale 1ns/10ps
`default_nettype none
module osmc_mode_ctrl
  import osmc_pkg::*;
#(
  parameter int unsigned SEC_DIV = SEC_CYCLES,
  parameter int unsigned FRAME_SEC = FRAME_SEC_DEF,
  parameter int unsigned HIGH_PULSES = HIGH_PULSES_DEF,
  parameter int unsigned LOW_PULSES = LOW_PULSES_DEF
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // command pulses
  input wire logic i_comfort_btn,
  input wire logic i_saving_btn,
  input wire logic i_off_btn,
  input wire logic i_off_timer,
  input wire logic i_unit_onoff_btn,
  input wire logic i_boost_sel,
  input wire logic i_quiet_sel,
  input wire logic i_airdir_btn,
  input wire logic i_fan_btn,
  input wire logic i_vlouver_btn,
  input wire logic i_check_cmd,
  input wire logic i_other_cmd,
  input wire logic i_home_automation_input,
  input wire logic i_on_timer,
  input wire logic i_set_temp_change,
  // status and sensors
  input wire logic i_sensor_err,
  input wire logic i_demo,
  input wire logic [7:0] i_err_level,
  input wire logic [1:0] i_op_mode,
  input wire logic [AREAS-1:0] i_ir_pulse,
  input wire logic i_sensor_power,
  input wire logic i_sensor_angle_motor,
  input wire logic [1:0] i_nonliving_pos,
  input wire logic i_pos_remote_set,
  input wire logic [1:0] i_pos_remote,
  input wire logic i_panel_open,
  // outputs
  output logic o_comfort_on,
  output logic o_saving_on,
  output logic [AREAS-1:0] o_area_present,
  output logic [AREAS-1:0] o_area_absent,
  output logic [1:0] o_activity,
  output logic o_room_absent,
  output logic [1:0] o_louver_center,
  output logic signed [3:0] o_temp_shift,
  output logic o_check_on,
  output logic [1:0] o_sensor_angle,
  output logic o_timer_led,
  output logic o_saving_led,
  output logic o_force_off,
  output logic o_panel_open_cmd,
  output logic o_cmd_ignored,
  output logic o_sun_clear
);
  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  localparam int SW = AREAS + 5;
  logic [SW-1:0] sync1_q, sync2_q;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {i_ir_pulse, i_sensor_power, i_sensor_angle_motor,
                  i_panel_open, i_sensor_err, i_demo};
      sync2_q <= sync1_q;
    end
  end
  logic [AREAS-1:0] ir_s, ir_prev_q, ir_edge;
  logic pwr_s, motor_s, panel_s, serr_s, demo_s, pwr_prev_q, panel_prev_q;
  assign {ir_s, pwr_s, motor_s, panel_s, serr_s, demo_s} = sync2_q;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      ir_prev_q <= '0;
      pwr_prev_q <= 1'b0;
      panel_prev_q <= 1'b0;
    end else begin
      ir_prev_q <= ir_s;
      pwr_prev_q <= pwr_s;
      panel_prev_q <= panel_s;
    end
  end
  assign ir_edge = ir_s & ~ir_prev_q;

  ////////////////////////////////////////////////////////////////////////
  // one-second enable
  logic [27:0] div_q;
  logic sec_tick;
  assign sec_tick = (div_q == 28'(SEC_DIV - 1));
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) div_q <= '0;
    else if (sec_tick) div_q <= '0;
    else div_q <= div_q + 28'h1;
  end

  ////////////////////////////////////////////////////////////////////////
  // comfort and saving modes
  logic common_stop, big_err, check_q, comfort_start, saving_start;
  assign common_stop = i_off_btn | i_off_timer | i_unit_onoff_btn;
  assign big_err = (i_err_level >= 8'(ERR_LEVEL_LIMIT));
  assign comfort_start = i_comfort_btn & !o_comfort_on;
  assign saving_start = i_saving_btn & !o_saving_on & !comfort_start;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) o_comfort_on <= 1'b0;
    else if (common_stop | i_boost_sel | i_quiet_sel | saving_start
             | i_airdir_btn | i_fan_btn) o_comfort_on <= 1'b0;
    else if (i_comfort_btn) o_comfort_on <= !o_comfort_on;
  end
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) o_saving_on <= 1'b0;
    else if (common_stop | i_fan_btn | i_vlouver_btn) o_saving_on <= 1'b0;
    else if (i_boost_sel | i_quiet_sel | comfort_start)
      o_saving_on <= 1'b0;
    else if (i_saving_btn) o_saving_on <= !o_saving_on;
  end

  ////////////////////////////////////////////////////////////////////////
  // activity frames per area
  logic [15:0] frame_q;
  logic frame_end;
  assign frame_end = sec_tick && (frame_q == 16'(FRAME_SEC - 1));
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) frame_q <= '0;
    else if (frame_end) frame_q <= '0;
    else if (sec_tick) frame_q <= frame_q + 16'h1;
  end
  logic [AREAS-1:0][15:0] cnt_q, quiet_q, absent_sec_q;
  logic [AREAS-1:0][2:0] lowrun_q;
  logic [15:0] total_pulses;
  always_comb begin
    total_pulses = '0;
    for (int i = 0; i < AREAS; i++) total_pulses = total_pulses + cnt_q[i];
  end
  for (genvar a = 0; a < AREAS; a++) begin : g_area
    always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
        cnt_q[a] <= '0;
        o_area_present[a] <= 1'b0;
      end else if (frame_end) begin
        o_area_present[a] <= (cnt_q[a] != 16'h0) | ir_edge[a];
        cnt_q[a] <= 16'(ir_edge[a]);
      end else if (ir_edge[a] && cnt_q[a] != 16'hffff) begin
        cnt_q[a] <= cnt_q[a] + 16'h1;
      end
    end
    always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) quiet_q[a] <= '0;
      else if (ir_edge[a]) quiet_q[a] <= '0;
      else if (sec_tick && quiet_q[a] < 16'(ABSENT_SEC))
        quiet_q[a] <= quiet_q[a] + 16'h1;
    end
    always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) lowrun_q[a] <= '0;
      else if (frame_end) begin
        if (cnt_q[a] >= 16'(LOW_PULSES)) lowrun_q[a] <= '0;
        else if (lowrun_q[a] < 3'(LOW_CYCLES_FOR_ABSENT))
          lowrun_q[a] <= lowrun_q[a] + 3'h1;
      end
    end
    always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) o_area_absent[a] <= 1'b0;
      else o_area_absent[a] <= (quiet_q[a] >= 16'(ABSENT_SEC)) &&
        (lowrun_q[a] >= 3'(LOW_CYCLES_FOR_ABSENT));
    end
    always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) absent_sec_q[a] <= '0;
      else if (!o_area_absent[a]) absent_sec_q[a] <= '0;
      else if (sec_tick && absent_sec_q[a] <= 16'(ROOM_ABSENT_SEC))
        absent_sec_q[a] <= absent_sec_q[a] + 16'h1;
    end
  end
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) o_activity <= OSMC_ACT_LOW;
    else if (frame_end) begin
      if (total_pulses >= 16'(HIGH_PULSES)) o_activity <= OSMC_ACT_HIGH;
      else if (total_pulses >= 16'(LOW_PULSES))
        o_activity <= OSMC_ACT_NORMAL;
      else o_activity <= OSMC_ACT_LOW;
    end
  end
  logic all_long_absent, lowish;
  always_comb begin
    all_long_absent = 1'b1;
    for (int i = 0; i < AREAS; i++)
      if (absent_sec_q[i] <= 16'(ROOM_ABSENT_SEC)) all_long_absent = 1'b0;
  end
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) o_room_absent <= 1'b0;
    else o_room_absent <= all_long_absent;
  end

  ////////////////////////////////////////////////////////////////////////
  // installation position and louver centre
  logic [15:0] rejudge_q;
  logic rejudge;
  assign rejudge = sec_tick && (rejudge_q == 16'(REJUDGE_SEC - 1));
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) rejudge_q <= '0;
    else if (rejudge) rejudge_q <= '0;
    else if (sec_tick) rejudge_q <= rejudge_q + 16'h1;
  end
  logic [1:0] auto_pos_q, pos_sel;
  logic first_q;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      auto_pos_q <= OSMC_POS_OTHER;
      first_q <= 1'b1;
    end else if (rejudge || first_q) begin
      auto_pos_q <= i_nonliving_pos;
      first_q <= 1'b0;
    end
  end
  assign pos_sel = i_pos_remote_set ? i_pos_remote : auto_pos_q;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) o_louver_center <= OSMC_LOUV_CENTER;
    else case (pos_sel)
      OSMC_POS_A: o_louver_center <= OSMC_LOUV_RIGHT;
      OSMC_POS_C: o_louver_center <= OSMC_LOUV_LEFT;
      default: o_louver_center <= OSMC_LOUV_CENTER;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // set temperature shift
  assign lowish = (o_activity == OSMC_ACT_LOW) | o_room_absent;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) o_temp_shift <= SHIFT_NONE;
    else if (!o_saving_on) o_temp_shift <= SHIFT_NONE;
    else if ((i_op_mode == OSMC_OPM_COOL || i_op_mode == OSMC_OPM_DRY)
             && lowish) o_temp_shift <= SHIFT_COOL;
    else if (i_op_mode == OSMC_OPM_HEAT &&
             (o_activity == OSMC_ACT_HIGH || o_room_absent))
      o_temp_shift <= SHIFT_HEAT;
    else o_temp_shift <= SHIFT_NONE;
  end

  ////////////////////////////////////////////////////////////////////////
  // sensor check mode
  logic [8:0] chk_sec_q;
  logic chk_enter, chk_exit, permitted;
  assign chk_enter = i_check_cmd && !serr_s && !demo_s && !big_err;
  assign chk_exit = i_other_cmd | i_unit_onoff_btn | serr_s | big_err
    | (sec_tick && chk_sec_q == 9'(CHECK_SEC - 1));
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) check_q <= 1'b0;
    else if (check_q && chk_exit) check_q <= 1'b0;
    else if (chk_enter) check_q <= 1'b1;
  end
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) chk_sec_q <= '0;
    else if (i_check_cmd) chk_sec_q <= '0;
    else if (check_q && sec_tick) chk_sec_q <= chk_sec_q + 9'h1;
  end
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) o_sensor_angle <= OSMC_ANG_FRONT;
    else if (!check_q) o_sensor_angle <= OSMC_ANG_FRONT;
    else if (i_check_cmd) begin
      case (o_sensor_angle)
        OSMC_ANG_FRONT: o_sensor_angle <= OSMC_ANG_LEFT;
        OSMC_ANG_LEFT: o_sensor_angle <= OSMC_ANG_RIGHT;
        default: o_sensor_angle <= OSMC_ANG_FRONT;
      endcase
    end
  end
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) o_check_on <= 1'b0;
    else o_check_on <= check_q;
  end

  ////////////////////////////////////////////////////////////////////////
  // detection permission
  logic [6:0] blind_q;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) blind_q <= 7'(PWR_BLIND_SEC);
    else if (pwr_s && !pwr_prev_q) blind_q <= 7'(PWR_BLIND_SEC);
    else if (motor_s) begin
      if (blind_q < 7'(MOTOR_BLIND_SEC)) blind_q <= 7'(MOTOR_BLIND_SEC);
    end else if (sec_tick && blind_q != 7'h0) blind_q <= blind_q - 7'h1;
  end
  assign permitted = pwr_s && !motor_s && (blind_q == 7'h0);

  ////////////////////////////////////////////////////////////////////////
  // led reporting
  logic [1:0] led_sec_q;
  logic seen_q, led_tick;
  assign led_tick = sec_tick && (led_sec_q == 2'(LED_UPDATE_SEC - 1));
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) led_sec_q <= '0;
    else if (!check_q || led_tick) led_sec_q <= '0;
    else if (sec_tick) led_sec_q <= led_sec_q + 2'h1;
  end
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) seen_q <= 1'b0;
    else if (!check_q || led_tick) seen_q <= 1'b0;
    else if (|ir_edge && permitted) seen_q <= 1'b1;
  end
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_timer_led <= 1'b0;
      o_saving_led <= 1'b0;
    end else if (!check_q) begin
      o_timer_led <= 1'b0;
      o_saving_led <= 1'b0;
    end else if (led_tick) begin
      o_timer_led <= seen_q | (|ir_edge && permitted);
      o_saving_led <= permitted;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // unit state during check, sunlight clear
  logic opm_change;
  logic [1:0] opm_q;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) opm_q <= OSMC_OPM_COOL;
    else opm_q <= i_op_mode;
  end
  assign opm_change = (opm_q != i_op_mode) && !(
    (opm_q == OSMC_OPM_COOL || opm_q == OSMC_OPM_DRY) &&
    (i_op_mode == OSMC_OPM_COOL || i_op_mode == OSMC_OPM_DRY));
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_force_off <= 1'b0;
      o_panel_open_cmd <= 1'b0;
      o_cmd_ignored <= 1'b0;
      o_sun_clear <= 1'b0;
    end else begin
      o_force_off <= check_q;
      o_panel_open_cmd <= check_q;
      o_cmd_ignored <= check_q &&
        (i_home_automation_input | i_on_timer);
      o_sun_clear <= saving_start | i_set_temp_change | opm_change
        | (panel_s && !panel_prev_q);
    end
  end
endmodule
`default_nettype wire

/* osmc_mode_ctrl_properties.sv */
// checker properties for the occupancy sensing mode control block
`timescale 1ns/10ps
`default_nettype none
module osmc_mode_ctrl_chk
  import osmc_pkg::*;
#(
  parameter int unsigned SEC_DIV = SEC_CYCLES
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // commands and status
  input wire logic i_comfort_btn,
  input wire logic i_saving_btn,
  input wire logic i_off_btn,
  input wire logic i_off_timer,
  input wire logic i_unit_onoff_btn,
  input wire logic i_boost_sel,
  input wire logic i_quiet_sel,
  input wire logic i_airdir_btn,
  input wire logic i_fan_btn,
  input wire logic i_vlouver_btn,
  input wire logic i_check_cmd,
  input wire logic i_other_cmd,
  input wire logic i_home_automation_input,
  input wire logic i_on_timer,
  input wire logic i_set_temp_change,
  input wire logic i_sensor_err,
  input wire logic i_demo,
  input wire logic [7:0] i_err_level,
  // watched outputs
  input wire logic o_comfort_on,
  input wire logic o_saving_on,
  input wire logic signed [3:0] o_temp_shift,
  input wire logic o_check_on,
  input wire logic [1:0] o_sensor_angle,
  input wire logic o_force_off,
  input wire logic o_panel_open_cmd,
  input wire logic o_cmd_ignored,
  input wire logic o_sun_clear
);
  localparam int unsigned LIM = CHECK_SEC * SEC_DIV + 4;
  logic [31:0] run_q;
  wire logic off_any = i_off_btn | i_off_timer | i_unit_onoff_btn;
  wire logic c_stop = off_any | i_boost_sel | i_quiet_sel | i_airdir_btn |
    i_fan_btn | i_saving_btn;
  wire logic s_stop = off_any | i_boost_sel | i_quiet_sel | i_fan_btn |
    i_vlouver_btn;
  wire logic clean = !i_sensor_err && !i_demo && i_err_level < 8'h14;
  wire logic [1:0] nxt_ang = o_sensor_angle == OSMC_ANG_FRONT ? OSMC_ANG_LEFT :
    o_sensor_angle == OSMC_ANG_LEFT ? OSMC_ANG_RIGHT : OSMC_ANG_FRONT;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  ////////////////////////////////////////////////////////////////////////////
  // cycles since the last check command while check mode runs
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      run_q <= 32'h0;
    end else if (!o_check_on || i_check_cmd) begin
      run_q <= 32'h0;
    end else begin
      run_q <= run_q + 32'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  comfort_start_a: assert property (
    i_comfort_btn && !o_comfort_on && !c_stop && !o_check_on |=> o_comfort_on)
    else $error("comfort mode did not start");
  comfort_stop_a: assert property (
    o_comfort_on && (c_stop || i_comfort_btn) &&
    !(i_comfort_btn && i_saving_btn) |=> !o_comfort_on)
    else $error("comfort mode did not stop");
  saving_start_a: assert property (
    i_saving_btn && !o_saving_on && !s_stop && !i_comfort_btn && !o_check_on
    |=> o_saving_on) else $error("saving mode did not start");
  saving_stop_a: assert property (
    o_saving_on && (s_stop || i_comfort_btn) |=> !o_saving_on)
    else $error("saving mode did not stop");
  modes_apart_a: assert property (
    !(o_comfort_on && o_saving_on)) else $error("both modes on");
  sun_clear_a: assert property (
    i_set_temp_change |=> o_sun_clear) else $error("sunlight not cleared");
  shift_idle_a: assert property (
    !o_saving_on && !$past(o_saving_on) |-> o_temp_shift == SHIFT_NONE)
    else $error("shift outside saving mode");
  check_refuse_a: assert property (
    i_check_cmd && !o_check_on && !$past(i_check_cmd) &&
    i_err_level >= 8'h14 |-> ##2 !o_check_on) else $error("check not refused");
  check_enter_a: assert property (
    i_check_cmd && !o_check_on && !$past(i_check_cmd) && clean &&
    $past(clean) && $past(clean, 2) && $past(clean, 3) ##1
    !i_other_cmd && !i_unit_onoff_btn && !i_check_cmd && clean |->
    ##1 o_check_on && o_force_off && o_panel_open_cmd &&
    o_sensor_angle == OSMC_ANG_FRONT) else $error("check entry wrong");
  check_exit_a: assert property (
    o_check_on && (i_other_cmd || i_unit_onoff_btn) && !i_check_cmd
    |-> ##2 !o_check_on) else $error("check mode did not end");
  angle_step_a: assert property (
    i_check_cmd ##1 o_check_on |-> o_sensor_angle == $past(nxt_ang))
    else $error("angle step wrong");
  check_time_a: assert property (
    o_check_on |-> run_q <= LIM) else $error("check mode overran");
  ignore_cmd_a: assert property (
    (i_home_automation_input || i_on_timer) ##1 o_check_on |-> o_cmd_ignored)
    else $error("command not ignored");
  cover property (o_check_on && i_check_cmd);
  cover property ($rose(o_saving_on));
  cover property ($fell(o_check_on));
endmodule
bind osmc_mode_ctrl osmc_mode_ctrl_chk #(.SEC_DIV(SEC_DIV))
  u_osmc_mode_ctrl_chk (.*);
`default_nettype wire

/* osmc_mode_ctrl_tb_top.sv */
// self-checking bench for the occupancy sensing mode control block
`timescale 1ns/10ps
`default_nettype none
module osmc_mode_ctrl_tb_top;
  import osmc_pkg::*;
  logic i_clock = 1'h0;
  logic i_nrst = 1'h0;
  logic [14:0] cmd = 15'h0;
  logic i_sensor_err = 1'h0;
  logic i_demo = 1'h0;
  logic [7:0] i_err_level = 8'h0;
  logic [1:0] i_op_mode = 2'h0;
  logic [1:0] i_nonliving_pos = 2'h1;
  logic i_pos_remote_set = 1'h0;
  logic [1:0] i_pos_remote = 2'h2;
  logic i_panel_open = 1'h0;
  logic pulse_en = 1'h0;
  logic motor = 1'h0;
  wire logic [3:0] i_ir_pulse;
  wire logic i_sensor_power, i_sensor_angle_motor;
  wire logic i_comfort_btn, i_saving_btn, i_off_btn, i_off_timer;
  wire logic i_unit_onoff_btn, i_boost_sel, i_quiet_sel, i_airdir_btn;
  wire logic i_fan_btn, i_vlouver_btn, i_check_cmd, i_other_cmd;
  wire logic i_home_automation_input, i_on_timer, i_set_temp_change;
  logic o_comfort_on, o_saving_on, o_room_absent, o_check_on, o_timer_led;
  logic o_saving_led, o_force_off, o_panel_open_cmd, o_cmd_ignored;
  logic o_sun_clear;
  logic [3:0] o_area_present, o_area_absent;
  logic [1:0] o_activity, o_louver_center, o_sensor_angle;
  logic signed [3:0] o_temp_shift;
  int err_count = 0;
  int n_checks = 0;
  int n;
  assign {i_set_temp_change, i_on_timer, i_home_automation_input, i_other_cmd,
    i_check_cmd, i_vlouver_btn, i_fan_btn, i_airdir_btn, i_quiet_sel,
    i_boost_sel, i_unit_onoff_btn, i_off_timer, i_off_btn, i_saving_btn,
    i_comfort_btn} = cmd;
  always #2 i_clock = ~i_clock;
  osmc_mode_ctrl #(.SEC_DIV(10), .FRAME_SEC(2), .HIGH_PULSES(6),
    .LOW_PULSES(2)) u_osmc_mode_ctrl (.*);
  osmc_sensor_model u_osmc_sensor_model (.i_clock(i_clock),
    .i_pulse_en(pulse_en), .i_motor_run(motor), .o_ir_pulse(i_ir_pulse),
    .o_sensor_power(i_sensor_power),
    .o_sensor_angle_motor(i_sensor_angle_motor));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] seen,
    input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    if (err_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic gone(input int k, input int lim);
    if (k >= lim) begin
      err_count++;
      print_verdict();
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge i_clock);
    #1;
  endtask
  task automatic press(input int b);
    @(posedge i_clock);
    #1 cmd[b] = 1'h1;
    @(posedge i_clock);
    #1 cmd = 15'h0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic s_louver();
    cyc(3);
    chk("louver auto", o_louver_center, OSMC_LOUV_RIGHT);
    i_pos_remote_set = 1'h1;
    cyc(3);
    chk("louver remote", o_louver_center, OSMC_LOUV_LEFT);
  endtask
  task automatic s_comfort();
    int stops[9] = '{1, 2, 3, 4, 5, 6, 7, 8, 0};
    foreach (stops[k]) begin
      press(0);
      chk("comfort on", o_comfort_on, 1'h1);
      chk("saving cancelled", o_saving_on, 1'h0);
      press(stops[k]);
      chk("comfort stop", o_comfort_on, 1'h0);
    end
  endtask
  task automatic s_saving();
    int stops[9] = '{1, 3, 4, 8, 9, 5, 6, 0, 2};
    press(2);
    chk("saving off", o_saving_on, 1'h0);
    foreach (stops[k]) begin
      press(1);
      chk("saving on", o_saving_on, 1'h1);
      chk("sun clear start", o_sun_clear, 1'h1);
      press(stops[k]);
      chk("saving stop", o_saving_on, 1'h0);
    end
    press(1);
    cyc(2);
    chk("cool shift", o_temp_shift, SHIFT_COOL);
    press(14);
    chk("sun clear set", o_sun_clear, 1'h1);
    cyc(1);
    chk("sun clear pulse", o_sun_clear, 1'h0);
    i_op_mode = OSMC_OPM_HEAT;
    cyc(1);
    chk("sun clear mode", o_sun_clear, 1'h1);
    cyc(2);
    chk("heat low shift", o_temp_shift, SHIFT_NONE);
  endtask
  task automatic s_activity();
    cyc(700);
    pulse_en = 1'h1;
    for (n = 0; n < 100 && o_activity !== OSMC_ACT_HIGH; n++) cyc(1);
    gone(n, 100);
    chk("present", o_area_present[0], 1'h1);
    cyc(2);
    chk("heat shift", o_temp_shift, SHIFT_HEAT);
    pulse_en = 1'h0;
    for (n = 0; n < 100 && o_activity !== OSMC_ACT_LOW; n++) cyc(1);
    gone(n, 100);
    chk("activity low", o_activity, OSMC_ACT_LOW);
    for (n = 0; n < 18400 && o_area_absent[0] !== 1'h1; n++) cyc(1);
    gone(n, 18400);
    chk("absent late", n > 17000, 1'h1);
    chk("room not absent", o_room_absent, 1'h0);
  endtask
  task automatic s_check();
    logic [1:0] seq[3] = '{OSMC_ANG_LEFT, OSMC_ANG_RIGHT, OSMC_ANG_FRONT};
    i_err_level = 8'h14;
    press(10);
    cyc(2);
    chk("refused level", o_check_on, 1'h0);
    i_err_level = 8'h13;
    i_demo = 1'h1;
    cyc(3);
    press(10);
    cyc(2);
    chk("refused demo", o_check_on, 1'h0);
    i_demo = 1'h0;
    cyc(3);
    press(10);
    cyc(1);
    chk("check on", o_check_on, 1'h1);
    chk("forced off", o_force_off, 1'h1);
    chk("panel open", o_panel_open_cmd, 1'h1);
    chk("angle", o_sensor_angle, OSMC_ANG_FRONT);
    foreach (seq[k]) begin
      press(10);
      chk("angle step", o_sensor_angle, seq[k]);
    end
    press(12);
    chk("automation ignored", o_cmd_ignored, 1'h1);
    press(11);
    cyc(1);
    chk("check ended", o_check_on, 1'h0);
  endtask
  task automatic s_timeout();
    press(10);
    pulse_en = 1'h1;
    cyc(80);
    chk("timer led", o_timer_led, 1'h1);
    chk("saving led", o_saving_led, 1'h1);
    motor = 1'h1;
    cyc(40);
    chk("led motor", o_saving_led, 1'h0);
    motor = 1'h0;
    pulse_en = 1'h0;
    cyc(40);
    chk("led settle", o_saving_led, 1'h0);
    for (n = 160; n < 3100 && o_check_on === 1'h1; n++) cyc(1);
    gone(n, 3100);
    chk("check timeout", n >= 2992 && n <= 3001, 1'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(2);
    i_nrst = 1'h1;
    s_louver();
    s_comfort();
    s_saving();
    s_activity();
    s_check();
    s_timeout();
    print_verdict();
  end
endmodule
`default_nettype wire

/* osmc_pkg.sv */
// constants and types for the occupancy sensing mode control block
package osmc_pkg;
  // timebase: 250 MHz clock, one pulse per second
  localparam int unsigned CLK_HZ = 250000000;
  localparam int unsigned SEC_CYCLES = CLK_HZ;
  // times in their own units
  localparam int unsigned ABSENT_MIN_LO = 30;
  localparam int unsigned ROOM_ABSENT_MIN = 120;
  localparam int unsigned REJUDGE_HOURS = 4;
  localparam int unsigned CHECK_MIN = 5;
  localparam int unsigned LED_UPDATE_SEC = 3;
  localparam int unsigned PWR_BLIND_SEC = 65;
  localparam int unsigned MOTOR_BLIND_SEC = 10;
  localparam int unsigned LOW_CYCLES_FOR_ABSENT = 5;
  localparam int unsigned ERR_LEVEL_LIMIT = 20;
  // derived counts in seconds
  localparam int unsigned ABSENT_SEC = ABSENT_MIN_LO * 60;
  localparam int unsigned ROOM_ABSENT_SEC = ROOM_ABSENT_MIN * 60;
  localparam int unsigned REJUDGE_SEC = REJUDGE_HOURS * 3600;
  localparam int unsigned CHECK_SEC = CHECK_MIN * 60;
  // activity defaults
  localparam int unsigned FRAME_SEC_DEF = 60;
  localparam int unsigned HIGH_PULSES_DEF = 20;
  localparam int unsigned LOW_PULSES_DEF = 3;
  localparam int unsigned AREAS = 4;
  // temperature shifts in degrees, two's complement
  localparam logic signed [3:0] SHIFT_COOL = 4'sh1;
  localparam logic signed [3:0] SHIFT_HEAT = -4'sh2;
  localparam logic signed [3:0] SHIFT_NONE = 4'sh0;

  typedef enum logic [1:0] {
    OSMC_ACT_LOW = 2'b00,
    OSMC_ACT_NORMAL = 2'b01,
    OSMC_ACT_HIGH = 2'b10
  } osmc_act_e;

  typedef enum logic [1:0] {
    OSMC_LOUV_CENTER = 2'b00,
    OSMC_LOUV_RIGHT = 2'b01,
    OSMC_LOUV_LEFT = 2'b10
  } osmc_louv_e;

  typedef enum logic [1:0] {
    OSMC_ANG_FRONT = 2'b00,
    OSMC_ANG_LEFT = 2'b01,
    OSMC_ANG_RIGHT = 2'b10
  } osmc_ang_e;

  typedef enum logic [1:0] {
    OSMC_POS_OTHER = 2'b00,
    OSMC_POS_A = 2'b01,
    OSMC_POS_C = 2'b10
  } osmc_pos_e;

  typedef enum logic [1:0] {
    OSMC_OPM_COOL = 2'b00,
    OSMC_OPM_DRY = 2'b01,
    OSMC_OPM_HEAT = 2'b10,
    OSMC_OPM_FAN = 2'b11
  } osmc_opm_e;
endpackage

/* osmc_sensor_model.sv */
// infrared sensor and angle motor model for the mode control bench
`timescale 1ns/10ps
`default_nettype none
module osmc_sensor_model (
  // bench control
  input wire logic i_clock,
  input wire logic i_pulse_en,
  input wire logic i_motor_run,
  // sensor pins
  output logic [3:0] o_ir_pulse,
  output logic o_sensor_power,
  output logic o_sensor_angle_motor
);
  logic [1:0] ph_q;
  initial begin
    ph_q = 2'h0;
    o_ir_pulse = 4'h0;
    o_sensor_power = 1'h1;
    o_sensor_angle_motor = 1'h0;
  end
  // one pulse each fourth cycle on areas 0 and 2 while someone moves
  always @(posedge i_clock) begin
    ph_q <= ph_q + 2'h1;
    o_ir_pulse <= {2'h0, i_pulse_en && ph_q == 2'h0} * 4'h5;
    o_sensor_angle_motor <= i_motor_run;
  end
endmodule
`default_nettype wire
